// file: tlc_pkg.sv
// Purpose: Constants shared by the transmit lane control register bank and its datapath.
// Assumes: Word-addressed 32-bit register port, one clock, asynchronous active-high reset.
`default_nettype none
package tlc_pkg;
   localparam int unsigned TLC_DATA_W = 32;
   localparam int unsigned TLC_ADDR_W = 8;
   // Word indices; the lane 0 register sits at byte 0x4, one word above the common one.
   localparam logic [7:0] TLC_IDX_COMMON = 8'h00;
   localparam logic [7:0] TLC_IDX_LANE0 = 8'h01;
   // Common register fields.
   localparam int unsigned TLC_CMN_BYTE_REV_BIT = 0;
   localparam int unsigned TLC_CMN_BIT_REV_BIT = 1;
   localparam int unsigned TLC_CMN_SPARE_BIT = 2;
   // Lane register fields.
   localparam int unsigned TLC_LANE_INVERT_BIT = 0;
   localparam int unsigned TLC_LANE_POWER_OFF_BIT = 1;
   localparam int unsigned TLC_LANE_SPARE_LSB = 2;
   localparam int unsigned TLC_LANE_SPARE_W = 8;
   // Reset values.
   localparam logic TLC_CMN_SPARE_RST = 1'h0;
   localparam logic [7:0] TLC_LANE_SPARE_RST = 8'h00;
   localparam logic TLC_LANE_POWER_OFF_RST = 1'h0;
   localparam logic TLC_LANE_INVERT_RST = 1'h0;
   localparam logic [31:0] TLC_READ_ZERO = 32'h00000000;
   // Datapath defaults.
   localparam int unsigned TLC_PAR_W = 40;
   localparam int unsigned TLC_FIFO_DEPTH = 32;
   localparam int unsigned TLC_OCTETS = 4;
   localparam int unsigned TLC_LANES = 1;
endpackage
`default_nettype wire

// file: tlc_fifo.sv
// Purpose: Synchronous first-in first-out buffer with valid and ready on both sides.
// Assumes: Depth is a power of two.
// Notes: The read side shows the head entry combinationally while it is not empty.
`timescale 1ns/1ps
`default_nettype none
module tlc_fifo #(
   parameter int unsigned WIDTH = 40,
   parameter int unsigned DEPTH = 32
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int unsigned PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W:0] wr_ptr_reg;
   logic [PTR_W:0] rd_ptr_reg;
   logic full;
   logic empty;
   logic do_write;
   logic do_read;

   // The extra pointer bit tells a full buffer from an empty one.
   assign full = (wr_ptr_reg[PTR_W] != rd_ptr_reg[PTR_W]) &&
                 (wr_ptr_reg[PTR_W-1:0] == rd_ptr_reg[PTR_W-1:0]);
   assign empty = (wr_ptr_reg == rd_ptr_reg);
   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = mem[rd_ptr_reg[PTR_W-1:0]];
   assign do_write = i_in_valid && !full;
   assign do_read = i_out_ready && !empty;

   always_ff @(posedge i_clock) begin
      if (do_write) begin
         mem[wr_ptr_reg[PTR_W-1:0]] <= i_in_data;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         wr_ptr_reg <= '0;
      end else if (do_write) begin
         wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         rd_ptr_reg <= '0;
      end else if (do_read) begin
         rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: tlc_lane_ctrl.sv
// Purpose: Transmit lane control registers and the lane 0 transmit word reorder path.
// Assumes: Register port is word addressed with single-cycle writes and one-cycle read latency.
// Notes: Order settings are build-time parameters; lanes above 0 keep power-off low.
`timescale 1ns/1ps
`default_nettype none
module tlc_lane_ctrl #(
   parameter logic BIT_REVERSE = 1'b1,
   parameter logic BYTE_REVERSE = 1'b1,
   parameter int unsigned PAR_W = tlc_pkg::TLC_PAR_W,
   parameter int unsigned FIFO_DEPTH = tlc_pkg::TLC_FIFO_DEPTH,
   parameter int unsigned LANES = tlc_pkg::TLC_LANES
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [tlc_pkg::TLC_ADDR_W-1:0] i_address,
   input wire logic i_write,
   input wire logic [tlc_pkg::TLC_DATA_W-1:0] i_writedata,
   input wire logic i_read,
   output logic [tlc_pkg::TLC_DATA_W-1:0] o_readdata,
   output logic o_readdatavalid,
   output logic [LANES-1:0] o_lane_power_off,
   input wire logic i_tx_valid,
   output logic o_tx_ready,
   input wire logic [PAR_W-1:0] i_tx_data,
   output logic o_tx_valid,
   input wire logic i_tx_ready,
   output logic [PAR_W-1:0] o_tx_data
);
   import tlc_pkg::*;

   localparam int unsigned SYM_W = PAR_W / TLC_OCTETS;
   localparam int unsigned LVL_W = $clog2(FIFO_DEPTH) + 1;

   logic common_lane_spare_reg;
   logic [TLC_LANE_SPARE_W-1:0] lane0_spare_reg;
   logic lane0_power_off_reg;
   logic lane0_invert_reg;
   logic [TLC_DATA_W-1:0] common_lane_control;
   logic [TLC_DATA_W-1:0] lane_zero_control;
   logic [TLC_DATA_W-1:0] read_next;
   logic wr_common;
   logic wr_lane0;
   logic [TLC_DATA_W-1:0] readdata_reg;
   logic readdatavalid_reg;
   logic [LANES-1:0] power_off_reg;

   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [PAR_W-1:0] fifo_out_data;
   logic [PAR_W-1:0] octet_word;
   logic [PAR_W-1:0] mirror_word;
   logic [PAR_W-1:0] tx_next;
   logic tx_valid_reg;
   logic [PAR_W-1:0] tx_data_reg;
   logic tx_ready_reg;
   logic fifo_wr;
   logic fifo_rd;
   logic [LVL_W-1:0] level_reg;
   logic [LVL_W-1:0] level_next;

   // Register port.

   // Writes land on the same edge that presents them; there is never a wait.
   assign wr_common = i_write && (i_address == TLC_IDX_COMMON);
   assign wr_lane0 = i_write && (i_address == TLC_IDX_LANE0);

   // Only the spare bit of the common word is writable; the order bits are constants.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         common_lane_spare_reg <= TLC_CMN_SPARE_RST;
      end else if (wr_common) begin
         common_lane_spare_reg <= i_writedata[TLC_CMN_SPARE_BIT];
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         lane0_spare_reg <= TLC_LANE_SPARE_RST;
      end else if (wr_lane0) begin
         lane0_spare_reg <= i_writedata[TLC_LANE_SPARE_LSB +: TLC_LANE_SPARE_W];
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         lane0_power_off_reg <= TLC_LANE_POWER_OFF_RST;
      end else if (wr_lane0) begin
         lane0_power_off_reg <= i_writedata[TLC_LANE_POWER_OFF_BIT];
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         lane0_invert_reg <= TLC_LANE_INVERT_RST;
      end else if (wr_lane0) begin
         lane0_invert_reg <= i_writedata[TLC_LANE_INVERT_BIT];
      end
   end

   // Read images; anything not assigned here is reserved and stays zero.
   always_comb begin
      common_lane_control = TLC_READ_ZERO;
      common_lane_control[TLC_CMN_BYTE_REV_BIT] = BYTE_REVERSE;
      common_lane_control[TLC_CMN_BIT_REV_BIT] = BIT_REVERSE;
      common_lane_control[TLC_CMN_SPARE_BIT] = common_lane_spare_reg;
   end

   always_comb begin
      lane_zero_control = TLC_READ_ZERO;
      lane_zero_control[TLC_LANE_INVERT_BIT] = lane0_invert_reg;
      lane_zero_control[TLC_LANE_POWER_OFF_BIT] = lane0_power_off_reg;
      lane_zero_control[TLC_LANE_SPARE_LSB +: TLC_LANE_SPARE_W] = lane0_spare_reg;
   end

   // Unmapped words read as zero and writes to them are dropped without error.
   always_comb begin
      read_next = TLC_READ_ZERO;
      case (i_address)
         TLC_IDX_COMMON: begin
            read_next = common_lane_control;
         end
         TLC_IDX_LANE0: begin
            read_next = lane_zero_control;
         end
         default: begin
            read_next = TLC_READ_ZERO;
         end
      endcase
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         readdata_reg <= TLC_READ_ZERO;
      end else if (i_read) begin
         readdata_reg <= read_next;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         readdatavalid_reg <= 1'b0;
      end else begin
         readdatavalid_reg <= i_read;
      end
   end

   assign o_readdata = readdata_reg;
   assign o_readdatavalid = readdatavalid_reg;

   // Power-off vector. Lanes above 0 have no register here and hold normal mode.
   // The transport layer and the reset controller read this to shed lanes.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         power_off_reg <= '0;
      end else begin
         power_off_reg <= '0;
         power_off_reg[0] <= lane0_power_off_reg;
      end
   end

   assign o_lane_power_off = power_off_reg;

   // Transmit path: buffer, reorder, invert, then a registered output stage.

   tlc_fifo #(
      .WIDTH(PAR_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_in_valid(fifo_wr),
      .o_in_ready(fifo_in_ready),
      .i_in_data(i_tx_data),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(fifo_out_ready),
      .o_out_data(fifo_out_data)
   );

   // A word is taken only while the registered ready is high, so valid with ready is the
   // whole handshake and a source that holds its word until then never loses one.
   assign fifo_wr = i_tx_valid && tx_ready_reg && fifo_in_ready;
   assign fifo_rd = fifo_out_ready && fifo_out_valid;

   // Ready comes from a flip-flop, so it is worked out from the fill level after this edge.
   always_comb begin
      level_next = level_reg;
      if (fifo_wr && !fifo_rd) begin
         level_next = level_reg + 1'b1;
      end else if (fifo_rd && !fifo_wr) begin
         level_next = level_reg - 1'b1;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         level_reg <= '0;
      end else begin
         level_reg <= level_next;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         tx_ready_reg <= 1'b0;
      end else begin
         tx_ready_reg <= (level_next < FIFO_DEPTH);
      end
   end

   assign o_tx_ready = tx_ready_reg;

   // The same order settings serve every lane, so the reorder is built once, in the lane 0 path.
   genvar g;
   generate
      for (g = 0; g < TLC_OCTETS; g++) begin : g_octet
         // Octet g moves to slot 3-g when byte reversal is built in.
         assign octet_word[g*SYM_W +: SYM_W] = BYTE_REVERSE ?
            fifo_out_data[(TLC_OCTETS-1-g)*SYM_W +: SYM_W] :
            fifo_out_data[g*SYM_W +: SYM_W];
      end
      for (g = 0; g < PAR_W; g++) begin : g_mirror
         // Bit g swaps with bit PAR_W-1-g for MSB-first serialization.
         assign mirror_word[g] = BIT_REVERSE ? octet_word[PAR_W-1-g] : octet_word[g];
      end
   endgenerate

   assign tx_next = lane0_invert_reg ? ~mirror_word : mirror_word;

   // Output stage loads whenever it is empty or its word is being taken.
   assign fifo_out_ready = !tx_valid_reg || i_tx_ready;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         tx_valid_reg <= 1'b0;
      end else if (fifo_out_ready) begin
         tx_valid_reg <= fifo_out_valid;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         tx_data_reg <= '0;
      end else if (fifo_out_ready && fifo_out_valid) begin
         tx_data_reg <= tx_next;
      end
   end

   assign o_tx_valid = tx_valid_reg;
   assign o_tx_data = tx_data_reg;
endmodule
`default_nettype wire

// file: tlc_lane_ctrl_properties.sv
// Purpose: Port assertions for the transmit lane control register bank.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Read checks look back one cycle at the request address.
`timescale 1ns/1ps
`default_nettype none
module tlc_lane_ctrl_checker #(
   parameter logic BIT_REVERSE = 1'b1,
   parameter logic BYTE_REVERSE = 1'b1,
   parameter int unsigned LANES = 1
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [tlc_pkg::TLC_ADDR_W-1:0] i_address,
   input wire logic i_write,
   input wire logic [tlc_pkg::TLC_DATA_W-1:0] i_writedata,
   input wire logic i_read,
   input wire logic [tlc_pkg::TLC_DATA_W-1:0] o_readdata,
   input wire logic o_readdatavalid,
   input wire logic [LANES-1:0] o_lane_power_off
);
   import tlc_pkg::*;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   sequence lane_wr_then_rd;
      i_write && !i_read && i_address == TLC_IDX_LANE0 ##1
         i_read && !i_write && i_address == TLC_IDX_LANE0;
   endsequence
   a_read_answer: assert property (i_read |=> o_readdatavalid)
      else $error("read not answered in the next cycle");
   a_no_stray_valid: assert property (!i_read |=> !o_readdatavalid)
      else $error("read valid without a read");
   a_common_fixed: assert property (o_readdatavalid && $past(i_address) == TLC_IDX_COMMON
      |-> o_readdata[31:3] == 29'h0 && o_readdata[1:0] == {BIT_REVERSE, BYTE_REVERSE})
      else $error("common register fixed bits wrong");
   a_lane_reserved: assert property (o_readdatavalid && $past(i_address) == TLC_IDX_LANE0
      |-> o_readdata[31:10] == 22'h0)
      else $error("lane register reserved bits not zero");
   a_unmapped_zero: assert property (o_readdatavalid && $past(i_address) > TLC_IDX_LANE0
      |-> o_readdata == TLC_READ_ZERO)
      else $error("unmapped read not zero");
   a_power_follow: assert property (i_write && i_address == TLC_IDX_LANE0
      |-> ##2 o_lane_power_off[0] == $past(i_writedata[1], 2))
      else $error("power off output does not follow its bit");
   a_readdata_hold: assert property (!i_read |=> $stable(o_readdata))
      else $error("read data changed without a read");
   a_lane_readback: assert property (lane_wr_then_rd |=>
      o_readdata[9:0] == $past(i_writedata[9:0], 2))
      else $error("lane register read back differs");
endmodule
bind tlc_lane_ctrl tlc_lane_ctrl_checker #(.BIT_REVERSE(BIT_REVERSE), .BYTE_REVERSE(BYTE_REVERSE),
   .LANES(LANES)) u_chk (.i_clock(i_clock), .i_rst(i_rst), .i_address(i_address),
   .i_write(i_write), .i_writedata(i_writedata), .i_read(i_read), .o_readdata(o_readdata),
   .o_readdatavalid(o_readdatavalid), .o_lane_power_off(o_lane_power_off));
`default_nettype wire

// file: tlc_lane_ctrl_tb.sv
// Purpose: Self-checking bench for the lane control registers and transmit reorder path.
// Assumes: Default build with both order settings at 1 and a 40-bit word.
// Notes: Words are offered two idle cycles apart so each offer sees a settled ready.
`timescale 1ns/1ps
`default_nettype none
module tlc_lane_ctrl_tb;
   import tlc_pkg::*;
   localparam int PW = 40;
   localparam int SW = PW / 4;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] i_address = 8'h00;
   logic i_write = 1'b0;
   logic [31:0] i_writedata = 32'h00000000;
   logic i_read = 1'b0;
   logic [31:0] o_readdata;
   logic o_readdatavalid;
   logic [0:0] o_lane_power_off;
   logic i_tx_valid = 1'b0;
   logic o_tx_ready;
   logic [PW-1:0] i_tx_data = '0;
   logic o_tx_valid;
   logic i_tx_ready = 1'b0;
   logic [PW-1:0] o_tx_data;
   logic [31:0] seed = 32'h36D62C71;
   logic [31:0] sink_seed = 32'h36D62C71;
   logic sink_rand = 1'b0;
   logic [PW-1:0] exp_q[$];
   int error_cnt = 0;
   int check_count = 0;
   always #2 i_clock = ~i_clock;
   tlc_lane_ctrl #(.PAR_W(PW)) uut (.i_clock(i_clock), .i_rst(i_rst), .i_address(i_address),
      .i_write(i_write), .i_writedata(i_writedata), .i_read(i_read), .o_readdata(o_readdata),
      .o_readdatavalid(o_readdatavalid), .o_lane_power_off(o_lane_power_off),
      .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready), .i_tx_data(i_tx_data),
      .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready), .o_tx_data(o_tx_data));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction
   // Octets reversed first, then the whole word mirrored, then the optional inversion.
   function automatic logic [PW-1:0] xform(input logic [PW-1:0] d, input logic inv);
      logic [PW-1:0] r;
      logic [PW-1:0] m;
      for (int i = 0; i < 4; i++) r[i*SW+:SW] = d[(3-i)*SW+:SW];
      for (int i = 0; i < PW; i++) m[i] = r[PW-1-i];
      return inv ? ~m : m;
   endfunction
   task automatic print_verdict;
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_write <= 1'b1;
      i_address <= a;
      i_writedata <= d;
      @(posedge i_clock);
      i_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_clock);
      i_read <= 1'b1;
      i_address <= a;
      @(posedge i_clock);
      i_read <= 1'b0;
      #1;
      check(o_readdatavalid === 1'b1 && o_readdata === e, "read data");
   endtask
   task automatic push(input logic inv, output logic ok);
      @(posedge i_clock);
      @(posedge i_clock);
      ok = (o_tx_ready === 1'b1);
      if (ok) begin
         seed = lfsr(seed);
         i_tx_data <= {seed[7:0], seed};
         i_tx_valid <= 1'b1;
         exp_q.push_back(xform({seed[7:0], seed}, inv));
         @(posedge i_clock);
         i_tx_valid <= 1'b0;
      end
   endtask
   task automatic drain;
      int n;
      n = 0;
      sink_rand = 1'b1;
      while (exp_q.size() > 0 && n < 500) begin
         @(posedge i_clock);
         n++;
      end
      if (exp_q.size() > 0) begin
         check(1'b0, "drain timeout");
         print_verdict();
      end
   endtask
   always @(posedge i_clock) begin
      sink_seed = lfsr(sink_seed);
      i_tx_ready <= sink_rand & sink_seed[0];
      if (!i_rst && o_tx_valid === 1'b1 && i_tx_ready === 1'b1) begin
         if (exp_q.size() == 0) check(1'b0, "extra word");
         else check(o_tx_data === exp_q.pop_front(), "word order");
      end
   end
   initial begin
      logic ok;
      int n;
      logic [31:0] d;
      repeat (2) @(posedge i_clock);
      i_rst <= 1'b0;
      rd(TLC_IDX_COMMON, 32'h00000003);
      rd(TLC_IDX_LANE0, 32'h00000000);
      wr(TLC_IDX_COMMON, 32'hFFFFFFFC);
      rd(TLC_IDX_COMMON, 32'h00000007);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         d = (i == 0) ? 32'hFFFFFFFF : seed;
         wr(TLC_IDX_LANE0, d);
         @(posedge i_clock);
         #1;
         check(o_lane_power_off[0] === d[1], "power off");
         rd(TLC_IDX_LANE0, d & 32'h000003FF);
      end
      wr(8'h05, 32'hFFFFFFFF);
      rd(8'h05, 32'h00000000);
      rd(TLC_IDX_LANE0, d & 32'h000003FF);
      // A write directly followed by a read of the same word, with no idle cycle between.
      @(posedge i_clock);
      i_write <= 1'b1;
      i_address <= TLC_IDX_LANE0;
      i_writedata <= 32'hFFFFFEA5;
      @(posedge i_clock);
      i_write <= 1'b0;
      i_read <= 1'b1;
      @(posedge i_clock);
      i_read <= 1'b0;
      #1;
      check(o_readdatavalid === 1'b1 && o_readdata === 32'h000002A5, "back to back");
      wr(TLC_IDX_LANE0, 32'h00000000);
      sink_rand = 1'b1;
      repeat (20) push(1'b0, ok);
      drain();
      wr(TLC_IDX_LANE0, 32'h00000001);
      sink_rand = 1'b0;
      n = 0;
      ok = 1'b1;
      while (ok && n < 40) begin
         push(1'b1, ok);
         if (ok) n++;
      end
      check(n == TLC_FIFO_DEPTH + 1, "buffer depth");
      drain();
      print_verdict();
   end
endmodule
`default_nettype wire
